// [rtl/ufl_interrupt_flags.sv]
// Status flags, enables and interrupt request of one UART channel.
// Assumes event pulses, FIFO state and receive data come from logic on clk;
// only the CTS pin is asynchronous and is synchronised here.
`timescale 1ns/1ns
module ufl_interrupt_flags
  import ufl_pkg::*;
#(
  parameter bit HAS_MODEM = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire ufl_bus_req_s bus_req,
  output logic [31:0]       reg_rdata,
  input  wire ufl_lin_ev_s  lin_ev,
  input  wire ufl_line_ev_s line_ev,
  input  wire logic         data_wake_ev,
  input  wire logic         cts_wake_ev,
  input  wire logic         tx_over_ev,
  input  wire logic         rx_over_ev,
  input  wire logic         rx_not_empty,
  input  wire logic         rx_activity,
  input  wire logic [7:0]   rx_data,
  input  wire logic         rda_flag,
  input  wire logic         thre_flag,
  input  wire logic         cts_pin,
  output logic              rx_buf_pop,
  output logic              irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [31:0] ier_r;
  logic [7:0]  cmp_r;
  logic [7:0]  dly_r;
  logic [7:0]  idle_cnt_r;
  logic [7:0]  idle_cnt_nxt;
  logic        tout_r;
  logic        cts_meta_r;
  logic        cts_sync_r;
  logic        cts_prev_r;
  logic        cts_chg_r;
  logic        data_wake_r;
  logic        cts_wake_r;
  logic        rx_over_r;
  logic        tx_over_r;
  logic        brk_r;
  logic        frm_r;
  logic        par_r;
  logic        hdr_det_r;
  logic        brk_det_r;
  logic        bit_err_r;
  logic        id_par_r;
  logic        hdr_fault_r;
  logic [31:0] rdata_r;
  logic [31:0] isr;
  logic [7:0]  terms;
  logic        lin_flag;
  logic        wake_flag;
  logic        buf_flag;
  logic        line_flag;
  logic        modem_flag;
  logic        wr_ier;
  logic        wr_tor;
  logic        wr_isr;
  logic        wr_fsr;
  logic        wr_msr;
  logic        wr_lsr;
  logic        wr_clr;
  logic        rd_rbr;
  logic [31:0] wd;

  // Set wins over clear for every sticky source bit
  function automatic logic w1c(input logic cur,
                               input logic set,
                               input logic clr);
    w1c = set | (cur & ~clr);
  endfunction : w1c

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  assign wd     = bus_req.wdata;
  assign wr_ier = bus_req.wr && (bus_req.addr == UFL_OFF_IER);
  assign wr_tor = bus_req.wr && (bus_req.addr == UFL_OFF_TOR);
  assign wr_isr = bus_req.wr && (bus_req.addr == UFL_OFF_ISR);
  assign wr_fsr = bus_req.wr && (bus_req.addr == UFL_OFF_FSR);
  assign wr_msr = bus_req.wr && (bus_req.addr == UFL_OFF_MSR);
  assign wr_lsr = bus_req.wr && (bus_req.addr == UFL_OFF_LSR);
  assign wr_clr = bus_req.wr && (bus_req.addr == UFL_OFF_CLR);
  assign rd_rbr = ce && bus_req.rd && (bus_req.addr == UFL_OFF_RBR);

  // Reading the receive buffer pops the FIFO outside
  assign rx_buf_pop = rd_rbr;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ier_r <= UFL_IER_RST;
    end else if (ce && wr_ier) begin
      ier_r <= wd;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_r <= UFL_TOR_RST;
      dly_r <= UFL_TOR_RST;
    end else if (ce && wr_tor) begin
      cmp_r <= wd[UFL_TOR_CMP_LSB +: 8];
      dly_r <= wd[UFL_TOR_DLY_LSB +: 8];
    end
  end

  // ----------------------------------------------------------------------
  // LIN sources
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hdr_det_r   <= 1'b0;
      brk_det_r   <= 1'b0;
      bit_err_r   <= 1'b0;
      id_par_r    <= 1'b0;
      hdr_fault_r <= 1'b0;
    end else if (ce) begin
      hdr_det_r   <= w1c(hdr_det_r, lin_ev.hdr_det,
                         (wr_lsr && wd[UFL_LSR_HDET]) ||
                         (wr_clr && wd[UFL_ISR_LIN]));
      brk_det_r   <= w1c(brk_det_r, lin_ev.brk_det,
                         (wr_lsr && wd[UFL_LSR_BKDET]) ||
                         (wr_clr && wd[UFL_ISR_LIN]));
      bit_err_r   <= w1c(bit_err_r, lin_ev.bit_err,
                         (wr_lsr && wd[UFL_LSR_BITER]) ||
                         (wr_clr && wd[UFL_ISR_LIN]));
      id_par_r    <= w1c(id_par_r, lin_ev.id_par,
                         (wr_lsr && wd[UFL_LSR_IDPAR]) ||
                         (wr_clr && wd[UFL_ISR_LIN]));
      hdr_fault_r <= w1c(hdr_fault_r, lin_ev.hdr_fault,
                         (wr_lsr && wd[UFL_LSR_HERR]) ||
                         (wr_clr && wd[UFL_ISR_LIN]));
    end
  end

  // Summary has no state of its own, so it drops with the last source
  assign lin_flag = hdr_det_r | brk_det_r | bit_err_r | id_par_r
                  | hdr_fault_r;

  // ----------------------------------------------------------------------
  // Wake-up sources
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_wake_r <= 1'b0;
      cts_wake_r  <= 1'b0;
    end else if (ce) begin
      data_wake_r <= w1c(data_wake_r, data_wake_ev,
                         (wr_isr && wd[UFL_ISR_DATWK]) ||
                         (wr_clr && wd[UFL_ISR_WAKE]));
      cts_wake_r  <= w1c(cts_wake_r, cts_wake_ev,
                         (wr_isr && wd[UFL_ISR_CTSWK]) ||
                         (wr_clr && wd[UFL_ISR_WAKE]));
    end
  end

  assign wake_flag = data_wake_r | cts_wake_r;

  // ----------------------------------------------------------------------
  // Overflow and receive line error sources
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_over_r <= 1'b0;
      tx_over_r <= 1'b0;
    end else if (ce) begin
      rx_over_r <= w1c(rx_over_r, rx_over_ev,
                       (wr_fsr && wd[UFL_FSR_RXOV]) ||
                       (wr_clr && wd[UFL_ISR_BUF]));
      tx_over_r <= w1c(tx_over_r, tx_over_ev,
                       (wr_fsr && wd[UFL_FSR_TXOV]) ||
                       (wr_clr && wd[UFL_ISR_BUF]));
    end
  end

  assign buf_flag = rx_over_r | tx_over_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      brk_r <= 1'b0;
      frm_r <= 1'b0;
      par_r <= 1'b0;
    end else if (ce) begin
      brk_r <= w1c(brk_r, line_ev.brk,
                   (wr_fsr && wd[UFL_FSR_BRK]) ||
                   (wr_clr && wd[UFL_ISR_RLS]));
      frm_r <= w1c(frm_r, line_ev.frm,
                   (wr_fsr && wd[UFL_FSR_FRM]) ||
                   (wr_clr && wd[UFL_ISR_RLS]));
      par_r <= w1c(par_r, line_ev.par,
                   (wr_fsr && wd[UFL_FSR_PAR]) ||
                   (wr_clr && wd[UFL_ISR_RLS]));
    end
  end

  assign line_flag = brk_r | frm_r | par_r;

  // ----------------------------------------------------------------------
  // Receive time-out
  // ----------------------------------------------------------------------
  // Counter waits at the compare value so one idle spell sets the flag once
  always_comb begin
    idle_cnt_nxt = idle_cnt_r;
    if (!rx_not_empty || rx_activity || rd_rbr) begin
      idle_cnt_nxt = 8'h00;
    end else if (idle_cnt_r != cmp_r) begin
      idle_cnt_nxt = idle_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_r <= 8'h00;
    end else if (ce) begin
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  // A zero compare value disables the time-out rather than firing at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tout_r <= 1'b0;
    end else if (ce) begin
      tout_r <= w1c(tout_r,
                    rx_not_empty && !rx_activity && !rd_rbr &&
                    (cmp_r != 8'h00) && (idle_cnt_r != cmp_r) &&
                    (idle_cnt_nxt == cmp_r),
                    rd_rbr || rx_activity ||
                    (wr_clr && wd[UFL_ISR_TOUT]));
    end
  end

  // ----------------------------------------------------------------------
  // CTS change detection
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_meta_r <= 1'b0;
      cts_sync_r <= 1'b0;
      cts_prev_r <= 1'b0;
    end else if (ce) begin
      cts_meta_r <= cts_pin;
      cts_sync_r <= cts_meta_r;
      cts_prev_r <= cts_sync_r;
    end
  end

  // Without modem logic the change bit is held at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cts_chg_r <= 1'b0;
    end else if (ce) begin
      cts_chg_r <= HAS_MODEM &&
                   w1c(cts_chg_r, cts_sync_r ^ cts_prev_r,
                       (wr_msr && wd[UFL_MSR_CHG]) ||
                       (wr_clr && wd[UFL_ISR_MODEM]));
    end
  end

  assign modem_flag = HAS_MODEM && cts_chg_r;

  // ----------------------------------------------------------------------
  // Status word and interrupt request
  // ----------------------------------------------------------------------
  always_comb begin
    terms = 8'h00;
    terms[UFL_ISR_RDA]   = rda_flag   && ier_r[UFL_IER_RDA];
    terms[UFL_ISR_THRE]  = thre_flag  && ier_r[UFL_IER_THRE];
    terms[UFL_ISR_RLS]   = line_flag  && ier_r[UFL_IER_RLS];
    terms[UFL_ISR_MODEM] = modem_flag && ier_r[UFL_IER_MODEM];
    terms[UFL_ISR_TOUT]  = tout_r     && ier_r[UFL_IER_TOUT];
    terms[UFL_ISR_BUF]   = buf_flag   && ier_r[UFL_IER_BUF];
    terms[UFL_ISR_WAKE]  = wake_flag  && ier_r[UFL_IER_WAKE];
    terms[UFL_ISR_LIN]   = lin_flag   && ier_r[UFL_IER_LIN];
  end

  always_comb begin
    isr = 32'h0000_0000;
    isr[UFL_ISR_RDA]   = rda_flag;
    isr[UFL_ISR_THRE]  = thre_flag;
    isr[UFL_ISR_RLS]   = line_flag;
    isr[UFL_ISR_MODEM] = modem_flag;
    isr[UFL_ISR_TOUT]  = tout_r;
    isr[UFL_ISR_BUF]   = buf_flag;
    isr[UFL_ISR_WAKE]  = wake_flag;
    isr[UFL_ISR_LIN]   = lin_flag;
    isr[UFL_ISR_IND +: 8] = terms;
    isr[UFL_ISR_CTSWK] = cts_wake_r;
    isr[UFL_ISR_DATWK] = data_wake_r;
  end

  // Combinational so the line follows the source flops in the same cycle
  assign irq = |terms;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      rdata_r <= 32'h0000_0000;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          UFL_OFF_RBR: rdata_r[7:0] <= rx_data;
          UFL_OFF_IER: rdata_r <= ier_r;
          UFL_OFF_ISR: rdata_r <= isr;
          UFL_OFF_TOR: begin
            rdata_r[UFL_TOR_CMP_LSB +: 8] <= cmp_r;
            rdata_r[UFL_TOR_DLY_LSB +: 8] <= dly_r;
          end
          UFL_OFF_FSR: begin
            rdata_r[UFL_FSR_RXOV]  <= rx_over_r;
            rdata_r[UFL_FSR_PAR]   <= par_r;
            rdata_r[UFL_FSR_FRM]   <= frm_r;
            rdata_r[UFL_FSR_BRK]   <= brk_r;
            rdata_r[UFL_FSR_RXEMP] <= !rx_not_empty;
            rdata_r[UFL_FSR_TXOV]  <= tx_over_r;
          end
          UFL_OFF_MSR: begin
            rdata_r[UFL_MSR_CHG] <= modem_flag;
            rdata_r[UFL_MSR_CTS] <= HAS_MODEM && cts_sync_r;
          end
          UFL_OFF_LSR: begin
            rdata_r[UFL_LSR_HDET]  <= hdr_det_r;
            rdata_r[UFL_LSR_HERR]  <= hdr_fault_r;
            rdata_r[UFL_LSR_IDPAR] <= id_par_r;
            rdata_r[UFL_LSR_BKDET] <= brk_det_r;
            rdata_r[UFL_LSR_BITER] <= bit_err_r;
          end
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;

endmodule : ufl_interrupt_flags

// [rtl/ufl_pkg.sv]
// Constants, register map and carrier types of the UART interrupt flag logic.
// Assumes a 32-bit register port and event pulses from the same clock domain.
package ufl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int          UFL_AW      = 8;
  localparam logic [7:0]  UFL_OFF_RBR = 8'h00;
  localparam logic [7:0]  UFL_OFF_IER = 8'h04;
  localparam logic [7:0]  UFL_OFF_FSR = 8'h18;
  localparam logic [7:0]  UFL_OFF_ISR = 8'h1C;
  localparam logic [7:0]  UFL_OFF_TOR = 8'h20;
  localparam logic [7:0]  UFL_OFF_MSR = 8'h28;
  localparam logic [7:0]  UFL_OFF_LSR = 8'h2C;
  localparam logic [7:0]  UFL_OFF_CLR = 8'h30;

  // ----------------------------------------------------------------------
  // Interrupt status flag positions
  // ----------------------------------------------------------------------
  localparam int UFL_ISR_RDA   = 0;
  localparam int UFL_ISR_THRE  = 1;
  localparam int UFL_ISR_RLS   = 2;
  localparam int UFL_ISR_MODEM = 3;
  localparam int UFL_ISR_TOUT  = 4;
  localparam int UFL_ISR_BUF   = 5;
  localparam int UFL_ISR_WAKE  = 6;
  localparam int UFL_ISR_LIN   = 7;
  localparam int UFL_ISR_IND   = 8;
  localparam int UFL_ISR_CTSWK = 16;
  localparam int UFL_ISR_DATWK = 17;

  // Interrupt enable positions
  localparam int UFL_IER_RDA   = 0;
  localparam int UFL_IER_THRE  = 1;
  localparam int UFL_IER_RLS   = 2;
  localparam int UFL_IER_MODEM = 3;
  localparam int UFL_IER_TOUT  = 4;
  localparam int UFL_IER_WAKE  = 6;
  localparam int UFL_IER_BUF   = 8;
  localparam int UFL_IER_LIN   = 9;

  // FIFO status positions
  localparam int UFL_FSR_RXOV  = 0;
  localparam int UFL_FSR_PAR   = 4;
  localparam int UFL_FSR_FRM   = 5;
  localparam int UFL_FSR_BRK   = 6;
  localparam int UFL_FSR_RXEMP = 14;
  localparam int UFL_FSR_TXOV  = 24;

  // Modem status, LIN status, time-out register fields
  localparam int UFL_MSR_CHG   = 0;
  localparam int UFL_MSR_CTS   = 4;
  localparam int UFL_LSR_HDET  = 0;
  localparam int UFL_LSR_HERR  = 1;
  localparam int UFL_LSR_IDPAR = 2;
  localparam int UFL_LSR_BKDET = 8;
  localparam int UFL_LSR_BITER = 9;
  localparam int UFL_TOR_CMP_LSB = 0;
  localparam int UFL_TOR_DLY_LSB = 8;

  // Reset values
  localparam logic [31:0] UFL_IER_RST = 32'h0000_0000;
  localparam logic [7:0]  UFL_TOR_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [UFL_AW-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } ufl_bus_req_s;

  typedef struct packed {
    logic hdr_det;
    logic brk_det;
    logic bit_err;
    logic id_par;
    logic hdr_fault;
  } ufl_lin_ev_s;

  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
  } ufl_line_ev_s;

endpackage : ufl_pkg

// [verification/ufl_flags_monitor.sv]
// Checker of the flag logic, watching the top module's ports only.
// Assumes one clock domain; it is bound from the testbench top file.
`timescale 1ns/1ns
module ufl_flags_monitor
  import ufl_pkg::*;
#(
  parameter bit HAS_MODEM = 1'b1
) (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         ce,
  input wire ufl_bus_req_s bus_req,
  input wire logic [31:0]  reg_rdata,
  input wire ufl_lin_ev_s  lin_ev,
  input wire ufl_line_ev_s line_ev,
  input wire logic         data_wake_ev,
  input wire logic         cts_wake_ev,
  input wire logic         tx_over_ev,
  input wire logic         rx_over_ev,
  input wire logic         rx_not_empty,
  input wire logic         rx_activity,
  input wire logic [7:0]   rx_data,
  input wire logic         rda_flag,
  input wire logic         thre_flag,
  input wire logic         cts_pin,
  input wire logic         rx_buf_pop,
  input wire logic         irq
);
  logic [31:0] ier_r;

  // Enable shadow: irq and the ISR indicator byte in reg_rdata are the windows on the gating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      ier_r <= UFL_IER_RST;
    else if (ce && bus_req.wr && bus_req.addr == UFL_OFF_IER)
      ier_r <= bus_req.wdata;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  lin_gate_a: assert property (
    ce && (|lin_ev) && ier_r[UFL_IER_LIN] |-> ##1 irq)
    else $error("LIN event did not raise irq");
  wake_gate_a: assert property (
    ce && (data_wake_ev || cts_wake_ev) && ier_r[UFL_IER_WAKE]
    |-> ##1 irq) else $error("wake event did not raise irq");
  buf_gate_a: assert property (
    ce && (tx_over_ev || rx_over_ev) && ier_r[UFL_IER_BUF]
    |-> ##1 irq) else $error("overflow did not raise irq");
  line_gate_a: assert property (
    ce && (|line_ev) && ier_r[UFL_IER_RLS] |-> ##1 irq)
    else $error("line error did not raise irq");
  modem_gate_a: assert property (
    HAS_MODEM && $changed(cts_pin) && ier_r[UFL_IER_MODEM]
    |-> ##[1:8] irq) else $error("CTS change did not raise irq");
  rbr_pop_a: assert property (
    rx_buf_pop == (bus_req.rd && ce && bus_req.addr == UFL_OFF_RBR))
    else $error("receive buffer pop mismatch");
  irq_masked_a: assert property (
    ier_r == 32'h0 |-> !irq) else $error("irq with all enables off");
  irq_sticky_a: assert property (
    irq && !bus_req.wr && !$past(bus_req.wr) && !bus_req.rd
    && !$past(bus_req.rd) && !rx_activity && !$past(rx_activity)
    |=> irq) else $error("irq dropped with no clear");

  cov_buf_c:   cover property (rx_over_ev && ier_r[UFL_IER_BUF]);
  cov_modem_c: cover property ($changed(cts_pin) && irq);
  cov_pop_c:   cover property (rx_buf_pop && rx_not_empty);
endmodule : ufl_flags_monitor

// [verification/ufl_interrupt_flags_test.sv]
// Testbench of the flag logic: register tasks, events and a line node.
// Assumes the package offsets and one-cycle read latency of the port.
`timescale 1ns/1ns
module ufl_interrupt_flags_test;
  import ufl_pkg::*;
  logic         clk, reset_n, ce, push, cts_flip;
  ufl_bus_req_s bus_req;
  logic [12:0]  ev;
  logic [31:0]  reg_rdata, rdata3, d, d3, xs;
  logic         rx_not_empty, rx_buf_pop, irq, irq3, cts_pin;
  logic [7:0]   rx_data;
  int           err_count, cmp_count, s, a, b;
  // Event index, source bit and summary bit of each flag source
  int           ev_b [12] = '{4, 3, 2, 1, 0, 7, 6, 5, 8, 9, 10, 11};
  int           src_b[12] = '{0, 8, 9, 2, 1, 6, 5, 4, 17, 16, 24, 0};
  int           sum_b[12] = '{7, 7, 7, 7, 7, 2, 2, 2, 6, 6, 5, 5};
  int           pa   [4]  = '{0, 8, 10, 5};
  int           pb   [4]  = '{4, 9, 11, 7};

  ufl_interrupt_flags u_dut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .bus_req(bus_req), .reg_rdata(reg_rdata), .lin_ev(ev[4:0]),
    .line_ev(ev[7:5]), .data_wake_ev(ev[8]), .cts_wake_ev(ev[9]),
    .tx_over_ev(ev[10]), .rx_over_ev(ev[11]), .rx_activity(ev[12]),
    .rx_not_empty(rx_not_empty), .rx_data(rx_data), .rda_flag(1'b0),
    .thre_flag(1'b0), .cts_pin(cts_pin), .rx_buf_pop(rx_buf_pop),
    .irq(irq));
  ufl_interrupt_flags #(.HAS_MODEM(1'b0)) u_dut3 (.clk(clk),
    .reset_n(reset_n), .ce(ce), .bus_req(bus_req), .reg_rdata(rdata3),
    .lin_ev(ev[4:0]), .line_ev(ev[7:5]), .data_wake_ev(ev[8]),
    .cts_wake_ev(ev[9]), .tx_over_ev(ev[10]), .rx_over_ev(ev[11]),
    .rx_activity(ev[12]), .rx_not_empty(rx_not_empty), .rx_data(rx_data),
    .rda_flag(1'b0), .thre_flag(1'b0), .cts_pin(cts_pin), .rx_buf_pop(),
    .irq(irq3));
  ufl_line_node u_node (.clk(clk), .reset_n(reset_n), .push(push),
    .cts_flip(cts_flip), .rx_buf_pop(rx_buf_pop),
    .rx_not_empty(rx_not_empty), .rx_data(rx_data), .cts_pin(cts_pin));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    bus_req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    d  = reg_rdata;
    d3 = rdata3;
  endtask : rd
  task automatic pulse(input logic [12:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 13'h0;
    #1;
  endtask : pulse
  task automatic wait_irq;
    for (int n = 0; n < 12 && irq !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_irq
  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  function automatic logic [7:0] src_reg(input int sm);
    return sm == UFL_ISR_LIN ? UFL_OFF_LSR :
           sm == UFL_ISR_WAKE ? UFL_OFF_ISR : UFL_OFF_FSR;
  endfunction : src_reg
  // Line and wake enables sit at their status positions
  function automatic int en_of(input int sm);
    return sm == UFL_ISR_LIN ? UFL_IER_LIN :
           sm == UFL_ISR_BUF ? UFL_IER_BUF : sm;
  endfunction : en_of

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    close_out();
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    reset_n  = 1'b0;
    ce       = 1'b1;
    push     = 1'b0;
    cts_flip = 1'b0;
    ev       = 13'h0;
    bus_req  = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(UFL_OFF_IER);
    chk(d, UFL_IER_RST);
    rd(UFL_OFF_TOR);
    chk(d, {24'h0, UFL_TOR_RST});
    rd(UFL_OFF_ISR);
    chk(d, 32'h0);
    // Each source alone: masked, enabled, then cleared by writing one
    for (int i = 0; i < 12; i++) begin
      s  = sum_b[i];
      xs = (32'h1 << s) | (s == UFL_ISR_WAKE ? 32'h1 << src_b[i] : 32'h0);
      wr(UFL_OFF_IER, 32'h0);
      pulse(13'h1 << ev_b[i]);
      rd(src_reg(s));
      chk(d[src_b[i]], 32'h1);
      rd(UFL_OFF_ISR);
      chk(d, xs);
      chk(irq, 32'h0);
      wr(UFL_OFF_IER, 32'h1 << en_of(s));
      rd(UFL_OFF_ISR);
      chk(d, xs | (32'h1 << (8 + s)));
      chk(irq, 32'h1);
      wr(src_reg(s), 32'h1 << src_b[i]);
      rd(UFL_OFF_ISR);
      chk(d, 32'h0);
      chk(irq, 32'h0);
    end
    // Two sources: summary holds until the last one is cleared
    for (int p = 0; p < 4; p++) begin
      a = pa[p];
      b = pb[p];
      s = sum_b[a];
      wr(UFL_OFF_IER, 32'h1 << en_of(s));
      pulse((13'h1 << ev_b[a]) | (13'h1 << ev_b[b]));
      wr(src_reg(s), 32'h1 << src_b[a]);
      rd(UFL_OFF_ISR);
      chk(d[s], 32'h1);
      chk(irq, 32'h1);
      wr(src_reg(s), 32'h1 << src_b[b]);
      rd(UFL_OFF_ISR);
      chk(d[s], 32'h0);
    end
    // CTS change; the second channel, u_dut3, has no modem flag
    wr(UFL_OFF_IER, 32'h1 << UFL_IER_MODEM);
    @(posedge clk);
    cts_flip <= 1'b1;
    @(posedge clk);
    cts_flip <= 1'b0;
    wait_irq();
    chk(irq, 32'h1);
    chk(irq3, 32'h0);
    rd(UFL_OFF_MSR);
    chk(d[UFL_MSR_CHG], 32'h1);
    chk(d3[UFL_MSR_CHG], 32'h0);
    rd(UFL_OFF_ISR);
    chk(d[UFL_ISR_MODEM], 32'h1);
    wr(UFL_OFF_MSR, 32'h1 << UFL_MSR_CHG);
    rd(UFL_OFF_ISR);
    chk(d, 32'h0);
    chk(irq, 32'h0);
    // Receive time-out after five idle cycles, cleared by a buffer read
    wr(UFL_OFF_TOR, 32'h5);
    wr(UFL_OFF_IER, 32'h1 << UFL_IER_TOUT);
    @(posedge clk);
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(irq, 32'h0);
    @(posedge clk);
    #1;
    chk(irq, 32'h1);
    rd(UFL_OFF_RBR);
    chk(d, 32'h5A);
    chk(rx_not_empty, 32'h0);
    rd(UFL_OFF_ISR);
    chk(d, 32'h0);
    // Receive activity restarts the idle count and drops the flag
    @(posedge clk);
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    wait_irq();
    chk(irq, 32'h1);
    pulse(13'h1 << 12);
    chk(irq, 32'h0);
    rd(UFL_OFF_RBR);
    chk(d, 32'h5B);
    // Refused accesses and the summary clear register
    rd(8'hFC);
    chk(d, 32'h0);
    wr(UFL_OFF_ISR, 32'hFFFF_FFFF);
    rd(UFL_OFF_ISR);
    chk(d, 32'h0);
    pulse(13'h1 << 11);
    wr(UFL_OFF_CLR, 32'h1 << UFL_ISR_BUF);
    rd(UFL_OFF_ISR);
    chk(d, 32'h0);
    rd(UFL_OFF_CLR);
    chk(d, 32'h0);
    // Clock enable low: an event in that cycle is not taken
    @(posedge clk);
    ce <= 1'b0;
    pulse(13'h1 << 11);
    @(posedge clk);
    ce <= 1'b1;
    rd(UFL_OFF_ISR);
    chk(d, 32'h0);
    close_out();
  end
endmodule : ufl_interrupt_flags_test

bind ufl_interrupt_flags ufl_flags_monitor #(.HAS_MODEM(HAS_MODEM)) u_mon (
  .clk(clk), .reset_n(reset_n), .ce(ce), .bus_req(bus_req),
  .reg_rdata(reg_rdata), .lin_ev(lin_ev), .line_ev(line_ev),
  .data_wake_ev(data_wake_ev), .cts_wake_ev(cts_wake_ev),
  .tx_over_ev(tx_over_ev), .rx_over_ev(rx_over_ev),
  .rx_not_empty(rx_not_empty), .rx_activity(rx_activity),
  .rx_data(rx_data), .rda_flag(rda_flag), .thre_flag(thre_flag),
  .cts_pin(cts_pin), .rx_buf_pop(rx_buf_pop), .irq(irq));

// [verification/ufl_line_node.sv]
// Far-side model: receive FIFO head and CTS pin of the remote node.
// Assumes the bench requests bytes and CTS flips on clk.
`timescale 1ns/1ns
module ufl_line_node (
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  push,
  input  wire logic  cts_flip,
  input  wire logic  rx_buf_pop,
  output logic       rx_not_empty,
  output logic [7:0] rx_data,
  output logic       cts_pin
);
  logic [7:0] cnt_r;
  logic [7:0] head_r;
  logic       pop;

  assign pop = rx_buf_pop && cnt_r != 8'h00;
  // Reading the buffer removes the head byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r  <= 8'h00;
      head_r <= 8'h5A;
    end else begin
      cnt_r  <= cnt_r + 8'(push) - 8'(pop);
      head_r <= head_r + 8'(pop);
    end
  end
  // Empty FIFO shows no stale byte, so a late read cannot pass by luck
  assign rx_not_empty = cnt_r != 8'h00;
  assign rx_data      = rx_not_empty ? head_r : ~head_r;
  // CTS level changes only on request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      cts_pin <= 1'b0;
    else if (cts_flip)
      cts_pin <= ~cts_pin;
  end
endmodule : ufl_line_node
